// File: rtl/bst_pkg.sv
// Package with constants and types for the boundary-scan test port.
package bst_pkg;

  // Register widths.
  localparam int IR_W  = 4;
  localparam int ID_W  = 32;
  localparam int BSC_W = 169;

  // Generic core pin groups covered by the boundary-scan chain.
  localparam int N_IN  = 8;
  localparam int N_OUT = 8;

  // Instruction codes.
  localparam logic [3:0] INS_EXTEST  = 4'h0;
  localparam logic [3:0] INS_SAMPLE  = 4'h1;
  localparam logic [3:0] INS_IDCODE  = 4'h2;
  localparam logic [3:0] INS_CLAMP   = 4'h3;
  localparam logic [3:0] INS_HIGHZ   = 4'h4;
  localparam logic [3:0] INS_BYPASS  = 4'hf;

  // Values after reset.
  localparam logic [3:0] IR_RST      = 4'h2;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;

  // Identification fields; the revision, device and maker values are arbitrary.
  localparam logic [3:0]  ID_REV     = 4'h1;
  localparam logic [15:0] ID_DEV     = 16'h5a5a;
  localparam logic [10:0] ID_MFR     = 11'h07e;
  localparam logic        ID_MARK    = 1'b1;

  // Chain layout: inputs at 0.., then output cells, then enable cells.
  localparam int POS_IN  = 0;
  localparam int POS_OUT = N_IN;
  localparam int POS_OE  = N_IN + N_OUT;

  // Test-reset input must be held this long to be seen.
  localparam int TRST_NS     = 50;
  localparam int CLK_NS      = 25;
  localparam int TRST_CYCLES = (TRST_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [15:0] {
    ST_TLR  = 16'h0001, ST_RTI  = 16'h0002, ST_SDRS = 16'h0004, ST_CDR  = 16'h0008,
    ST_SDR  = 16'h0010, ST_E1DR = 16'h0020, ST_PDR  = 16'h0040, ST_E2DR = 16'h0080,
    ST_UDR  = 16'h0100, ST_SIRS = 16'h0200, ST_CIR  = 16'h0400, ST_SIR  = 16'h0800,
    ST_E1IR = 16'h1000, ST_PIR  = 16'h2000, ST_E2IR = 16'h4000, ST_UIR  = 16'h8000
  } bst_state_t;

endpackage

// File: rtl/bst_tap.sv
// Boundary-scan test access port: TAP controller, instruction, bypass, ID and boundary chain.
//
// Functional notes
// RL1: Test reset low returns all scan logic to reset; undriven it reads high.
// RL2: Instruction register is four bits, shifted from TDI in Shift-IR.
// RL3: Current instruction selects the active data register and TDI-TDO path.
// RL4: Bypass stage is one flip-flop giving a one-bit path.
// RL5: Boundary chain cell 0 is the first bit out on TDO.
// RL6: Output-enable cells are active high.
// RL7: ID register is 32 bits: revision 31:28, device 27:12, maker 11:1.
// RL8: ID bit 0 always captures a constant one.
// RL9: Code 0000 selects boundary chain and drives its output cells onto pins.
// RL10: Code 1111 selects bypass and leaves normal operation alone.
// RL11: Code 0010 loads the fixed ID code and selects the ID register.
// RL12: Code 0100 selects bypass and floats every device output.
// RL13: Code 0011 selects bypass while chain output cells keep driving pins.
// RL14: Code 0001 selects boundary chain, captures pins, shifts new values in.
// RL15: Controller loads only the six defined codes; others are reserved. The code loads any code into ir_q and runs reserved ones as bypass.
// RL16: Pin control covers all outputs but TDO, inputs but TDI, TMS, reset.
// RL17: TMS and TDI are sampled on the rising TCK edge.
// RL18: TDO changes on falling TCK while shifting, otherwise high impedance.
// RL19: Standard sixteen-state TAP machine; five TMS-high cycles reach reset.
`timescale 1ns/1ps

module bst_tap (
  input  wire logic                     ref_clk,      // System clock, 40 MHz.
  input  wire logic                     arst_n,       // Asynchronous reset, active low.
  input  wire logic                     tck,          // Test clock pin.
  input  wire logic                     tms,          // Test mode select pin.
  input  wire logic                     tdi,          // Test data input pin.
  input  wire logic                     trst_n_i,     // Test reset pin input value.
  input  wire logic                     trst_n_oe,    // High while something drives the test reset pin.
  output logic                          tdo_o,        // Test data output value.
  output logic                          tdo_oe,       // Test data output enable.
  input  wire logic [bst_pkg::N_IN-1:0]  core_in,     // Pin inputs toward the core.
  input  wire logic [bst_pkg::N_OUT-1:0] core_out,    // Core output values.
  input  wire logic [bst_pkg::N_OUT-1:0] core_oe,     // Core output enables.
  output logic [bst_pkg::N_OUT-1:0]     pin_out,      // Values on device output pins.
  output logic [bst_pkg::N_OUT-1:0]     pin_oe        // Enables of device output pins.
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic [1:0] tck_s_q;
  logic       tck_d_q;
  logic [1:0] tms_s_q;
  logic [1:0] tdi_s_q;
  logic [1:0] trst_s_q;
  logic [1:0] trst_oe_s_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_s_q  <= 2'b00;
      tck_d_q  <= 1'b0;
      tms_s_q  <= 2'b11;
      tdi_s_q  <= 2'b11;
      trst_s_q    <= 2'b11;
      trst_oe_s_q <= 2'b00;
    end else begin
      tck_s_q  <= {tck_s_q[0], tck};
      tck_d_q  <= tck_s_q[1];
      tms_s_q  <= {tms_s_q[0], tms};
      tdi_s_q  <= {tdi_s_q[0], tdi};
      trst_s_q    <= {trst_s_q[0], trst_n_i};
      trst_oe_s_q <= {trst_oe_s_q[0], trst_n_oe};
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic tms_v;
  logic tdi_v;
  logic trst_act;

  // The test clock is sampled like any pin, so each of its phases must span at least three system clocks.
  assign tck_rise = tck_s_q[1] & ~tck_d_q;  // [RL17]
  assign tck_fall = ~tck_s_q[1] & tck_d_q;  // [RL18]
  assign tms_v    = tms_s_q[1];
  assign tdi_v    = tdi_s_q[1];
  // An undriven test reset reads as inactive.
  assign trst_act = trst_oe_s_q[1] & ~trst_s_q[1];  // [RL1]

  ////////////////////////////////////////////////////////////////////////////////
  // TAP controller.

  bst_pkg::bst_state_t st_q;
  bst_pkg::bst_state_t st_d;

  always_comb begin
    case (st_q)  // [RL19]
      bst_pkg::ST_TLR:  st_d = tms_v ? bst_pkg::ST_TLR  : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI:  st_d = tms_v ? bst_pkg::ST_SDRS : bst_pkg::ST_RTI;
      bst_pkg::ST_SDRS: st_d = tms_v ? bst_pkg::ST_SIRS : bst_pkg::ST_CDR;
      bst_pkg::ST_CDR:  st_d = tms_v ? bst_pkg::ST_E1DR : bst_pkg::ST_SDR;
      bst_pkg::ST_SDR:  st_d = tms_v ? bst_pkg::ST_E1DR : bst_pkg::ST_SDR;
      bst_pkg::ST_E1DR: st_d = tms_v ? bst_pkg::ST_UDR  : bst_pkg::ST_PDR;
      bst_pkg::ST_PDR:  st_d = tms_v ? bst_pkg::ST_E2DR : bst_pkg::ST_PDR;
      bst_pkg::ST_E2DR: st_d = tms_v ? bst_pkg::ST_UDR  : bst_pkg::ST_SDR;
      bst_pkg::ST_UDR:  st_d = tms_v ? bst_pkg::ST_SDRS : bst_pkg::ST_RTI;
      bst_pkg::ST_SIRS: st_d = tms_v ? bst_pkg::ST_TLR  : bst_pkg::ST_CIR;
      bst_pkg::ST_CIR:  st_d = tms_v ? bst_pkg::ST_E1IR : bst_pkg::ST_SIR;
      bst_pkg::ST_SIR:  st_d = tms_v ? bst_pkg::ST_E1IR : bst_pkg::ST_SIR;
      bst_pkg::ST_E1IR: st_d = tms_v ? bst_pkg::ST_UIR  : bst_pkg::ST_PIR;
      bst_pkg::ST_PIR:  st_d = tms_v ? bst_pkg::ST_E2IR : bst_pkg::ST_PIR;
      bst_pkg::ST_E2IR: st_d = tms_v ? bst_pkg::ST_UIR  : bst_pkg::ST_SIR;
      bst_pkg::ST_UIR:  st_d = tms_v ? bst_pkg::ST_SDRS : bst_pkg::ST_RTI;
      default:          st_d = bst_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= bst_pkg::ST_TLR;
    end else if (trst_act) begin
      st_q <= bst_pkg::ST_TLR;  // [RL1]
    end else if (tck_rise) begin
      st_q <= st_d;  // [RL17]
    end
  end

  // One-cycle strokes for each scan action, taken on the synchronised rising test clock.
  logic cap_ir;
  logic shift_ir;
  logic upd_ir;
  logic cap_dr;
  logic shift_dr;
  logic upd_dr;

  assign cap_ir   = tck_rise && (st_q == bst_pkg::ST_CIR);
  assign shift_ir = tck_rise && (st_q == bst_pkg::ST_SIR);  // [RL2]
  assign upd_ir   = tck_rise && (st_q == bst_pkg::ST_UIR);
  assign cap_dr   = tck_rise && (st_q == bst_pkg::ST_CDR);
  assign shift_dr = tck_rise && (st_q == bst_pkg::ST_SDR);
  assign upd_dr   = tck_rise && (st_q == bst_pkg::ST_UDR);

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction register and decode.

  logic [bst_pkg::IR_W-1:0] ir_sh_q;
  logic [bst_pkg::IR_W-1:0] ir_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_sh_q <= bst_pkg::IR_CAPTURE;
    end else if (trst_act || (st_q == bst_pkg::ST_TLR)) begin
      ir_sh_q <= bst_pkg::IR_CAPTURE;  // [RL1]
    end else if (cap_ir) begin
      ir_sh_q <= bst_pkg::IR_CAPTURE;
    end else if (shift_ir) begin
      ir_sh_q <= {tdi_v, ir_sh_q[bst_pkg::IR_W-1:1]};  // [RL2]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ir_q <= bst_pkg::IR_RST;
    end else if (trst_act || (st_q == bst_pkg::ST_TLR)) begin
      ir_q <= bst_pkg::IR_RST;  // [RL1]
    end else if (upd_ir) begin
      ir_q <= ir_sh_q;  // [RL2]
    end
  end

  // Which serial path an instruction selects; reserved codes fall back to bypass.
  function automatic logic [1:0] path_sel(input logic [3:0] ins);
    case (ins)  // [RL3]
      bst_pkg::INS_EXTEST: path_sel = 2'h2;  // [RL9]
      bst_pkg::INS_SAMPLE: path_sel = 2'h2;  // [RL14]
      bst_pkg::INS_IDCODE: path_sel = 2'h1;  // [RL11]
      default:             path_sel = 2'h0;  // [RL10] [RL12] [RL13] [RL15]
    endcase
  endfunction

  logic [1:0] sel;
  logic       sel_bsc;
  logic       sel_id;
  logic       force_pins;
  logic       float_pins;

  assign sel        = path_sel(ir_q);
  assign sel_bsc    = (sel == 2'h2);
  assign sel_id     = (sel == 2'h1);
  assign force_pins = (ir_q == bst_pkg::INS_EXTEST) || (ir_q == bst_pkg::INS_CLAMP);  // [RL9] [RL13]
  assign float_pins = (ir_q == bst_pkg::INS_HIGHZ);  // [RL12]

  ////////////////////////////////////////////////////////////////////////////////
  // Data registers: bypass stage, identification register, boundary chain.

  logic                      bypass_stage_q;
  logic [bst_pkg::ID_W-1:0]  identification_register_q;
  logic [bst_pkg::BSC_W-1:0] boundary_scan_chain_q;
  logic [bst_pkg::BSC_W-1:0] bsc_upd_q;
  logic [bst_pkg::BSC_W-1:0] bsc_cap;

  // Capture image: inputs, core outputs, core enables; spare cells keep their value.
  always_comb begin
    bsc_cap = boundary_scan_chain_q;
    bsc_cap[bst_pkg::POS_IN +: bst_pkg::N_IN]   = core_in;  // [RL16]
    bsc_cap[bst_pkg::POS_OUT +: bst_pkg::N_OUT] = core_out;
    bsc_cap[bst_pkg::POS_OE +: bst_pkg::N_OUT]  = core_oe;  // [RL6]
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bypass_stage_q <= 1'b0;
    end else if (trst_act) begin
      bypass_stage_q <= 1'b0;  // [RL1]
    end else if (cap_dr) begin
      bypass_stage_q <= 1'b0;
    end else if (shift_dr) begin
      bypass_stage_q <= tdi_v;  // [RL4]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      identification_register_q <= '0;
    end else if (trst_act) begin
      identification_register_q <= '0;  // [RL1]
    end else if (cap_dr && sel_id) begin
      identification_register_q <= {bst_pkg::ID_REV, bst_pkg::ID_DEV,
                                    bst_pkg::ID_MFR, bst_pkg::ID_MARK};  // [RL7] [RL8] [RL11]
    end else if (shift_dr && sel_id) begin
      identification_register_q <= {tdi_v, identification_register_q[bst_pkg::ID_W-1:1]};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      boundary_scan_chain_q <= '0;
    end else if (trst_act) begin
      boundary_scan_chain_q <= '0;  // [RL1]
    end else if (cap_dr && sel_bsc) begin
      boundary_scan_chain_q <= bsc_cap;  // [RL14]
    end else if (shift_dr && sel_bsc) begin
      boundary_scan_chain_q <= {tdi_v, boundary_scan_chain_q[bst_pkg::BSC_W-1:1]};  // [RL5]
    end
  end

  // Spare cells beyond the pin groups are latched here too but never reach a pin.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bsc_upd_q <= '0;
    end else if (trst_act) begin
      bsc_upd_q <= '0;  // [RL1]
    end else if (upd_dr && sel_bsc) begin
      bsc_upd_q <= boundary_scan_chain_q;  // [RL14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Test data output, updated on the falling test clock edge.

  logic tdo_bit;

  always_comb begin
    if (st_q == bst_pkg::ST_SIR) begin
      tdo_bit = ir_sh_q[0];
    end else if (sel_bsc) begin
      tdo_bit = boundary_scan_chain_q[0];  // [RL5]
    end else if (sel_id) begin
      tdo_bit = identification_register_q[0];
    end else begin
      tdo_bit = bypass_stage_q;  // [RL4]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (trst_act) begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo_o  <= tdo_bit;  // [RL18]
      tdo_oe <= (st_q == bst_pkg::ST_SDR) || (st_q == bst_pkg::ST_SIR);  // [RL18]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output pin multiplexing.

  // Pins follow a new instruction one system clock later; the core drives them while nothing forces or floats them.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else if (float_pins) begin
      pin_out <= core_out;
      pin_oe  <= '0;  // [RL12] [RL16]
    end else if (force_pins) begin
      pin_out <= bsc_upd_q[bst_pkg::POS_OUT +: bst_pkg::N_OUT];  // [RL9] [RL13]
      pin_oe  <= bsc_upd_q[bst_pkg::POS_OE +: bst_pkg::N_OUT];   // [RL6]
    end else begin
      pin_out <= core_out;  // [RL10]
      pin_oe  <= core_oe;
    end
  end

endmodule

// File: test/bst_tap_assertions.sv
// Concurrent checks on the ports of the boundary-scan test port.
`timescale 1ns/1ps
module bst_tap_assertions (
  input wire logic                        ref_clk,   // System clock.
  input wire logic                        arst_n,    // Reset, active low.
  input wire logic                        tck,       // Test clock.
  input wire logic                        tms,       // Mode select.
  input wire logic                        trst_n_i,  // Test reset level.
  input wire logic                        trst_n_oe, // Test reset driven.
  input wire logic                        tdo_o,     // Test data out.
  input wire logic                        tdo_oe,    // Test data out enable.
  input wire logic [bst_pkg::N_OUT-1:0] core_out,  // Core outputs.
  input wire logic [bst_pkg::N_OUT-1:0] core_oe,   // Core enables.
  input wire logic [bst_pkg::N_OUT-1:0] pin_out,   // Pin values.
  input wire logic [bst_pkg::N_OUT-1:0] pin_oe     // Pin enables.
);
  logic       trst_a;
  logic [1:0] tck_q;
  logic [2:0] ones_q;
  logic [3:0] wait_q;
  assign trst_a = trst_n_oe && !trst_n_i;
  // Counts rising test clocks with mode select high, then lets the port settle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_q  <= '0;
      ones_q <= '0;
      wait_q <= '0;
    end else begin
      tck_q <= {tck_q[0], tck};
      if (tck_q == 2'b01)
        ones_q <= !tms ? 3'd0 : (ones_q == 3'd5) ? ones_q : ones_q + 3'd1;
      if (tck_q == 2'b01 && !tms)
        wait_q <= '0;
      else if (ones_q == 3'd5 && wait_q != 4'd8)
        wait_q <= wait_q + 4'd1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_trst;
    trst_a [*5];
  endsequence
  sequence s_tlr;
    wait_q == 4'd8;
  endsequence
  AST_TRST_TDO: assert property (s_trst |-> !tdo_oe)
    else $error("data out driven during test reset");
  AST_TRST_PIN: assert property (s_trst |=> pin_oe == $past(core_oe) && pin_out == $past(core_out))
    else $error("pins not normal after test reset");
  AST_TLR_TDO: assert property (s_tlr |-> !tdo_oe)
    else $error("data out driven in logic reset");
  AST_TLR_PIN: assert property (s_tlr |-> pin_oe == $past(core_oe) && pin_out == $past(core_out))
    else $error("pins not normal in logic reset");
  AST_TDO_HOLD: assert property (tck && $past(tck) && !trst_a |-> $stable(tdo_o))
    else $error("data out moved in clock high phase");
  AST_OE_HOLD: assert property (tck && $past(tck) && !trst_a |-> $stable(tdo_oe))
    else $error("data enable moved in clock high phase");
  AST_OE_ROSE: assert property ($rose(tdo_oe) |-> !$past(tck))
    else $error("data enable rose off the falling edge");
  AST_OE_FELL: assert property ($fell(tdo_oe) && !trst_a |-> !$past(tck))
    else $error("data enable fell off the falling edge");
endmodule

bind bst_tap bst_tap_assertions i_bst_tap_assertions (.ref_clk(ref_clk), .arst_n(arst_n), .tck(tck), .tms(tms),
  .trst_n_i(trst_n_i), .trst_n_oe(trst_n_oe), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_out(core_out),
  .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));

// File: test/bst_jtag_ctl.sv
// Model of the external scan controller that drives the test pins.
`timescale 1ns/1ps
module bst_jtag_ctl (
  output logic      tck,       // Test clock, still between frames.
  output logic      tms,       // Mode select.
  output logic      tdi,       // Test data in.
  output logic      trst_n_i,  // Test reset level.
  output logic      trst_n_oe, // Test reset driven.
  input  wire logic tdo_o,     // Test data out.
  input  wire logic tdo_oe     // Test data out enable.
);
  initial begin
    tck       = 1'b0;
    tms       = 1'b1;
    tdi       = 1'b1;
    trst_n_i  = 1'b1;
    trst_n_oe = 1'b0;
  end
  // Inputs move at the falling edge; data out is taken late in the high phase.
  task automatic xfer(input logic [199:0] tm, ti, input int n, output logic [199:0] to, zo);
    to = '0;
    zo = '0;
    #7;
    for (int i = 0; i < n; i++) begin
      tms = tm[i];
      tdi = ti[i];
      #100 tck = 1'b1;
      #100 to[i] = tdo_o;
      zo[i] = tdo_oe;
      tck = 1'b0;
    end
    tms = 1'b1;
    tdi = 1'b1;
  endtask
  // Pulls test reset low for 150 ns, driven or with the driver off.
  task automatic pulse(input logic drv);
    trst_n_oe = drv;
    trst_n_i = 1'b0;
    #150 trst_n_i = 1'b1;
    trst_n_oe = 1'b0;
  endtask
endmodule

// File: test/bst_tap_tb.sv
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/1ps
module bst_tap_tb;
  logic         ref_clk, arst_n, tck, tms, tdi, trst_n_i, trst_n_oe, tdo_o, tdo_oe;
  logic [7:0]   core_in, core_out, core_oe, pin_out, pin_oe;
  logic [15:0]  ext;
  logic [199:0] exp_q[$], msk_q[$], obs_q[$], to, zo, p, q, m;
  logic [3:0]   bp[4] = '{bst_pkg::INS_CLAMP, bst_pkg::INS_HIGHZ, bst_pkg::INS_BYPASS, bst_pkg::INS_BYPASS};
  int           miscompares = 0, total_checks = 0, seed = 32'h0f65_4493;
  wire [15:0]   nrm = {core_oe, core_out};
  wire [199:0]  idv = 200'({bst_pkg::ID_REV, bst_pkg::ID_DEV, bst_pkg::ID_MFR, bst_pkg::ID_MARK});
  bst_tap i_bst_tap (.ref_clk(ref_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .trst_n_i(trst_n_i),
    .trst_n_oe(trst_n_oe), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_in(core_in), .core_out(core_out),
    .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe));
  bst_jtag_ctl i_bst_jtag_ctl (.tck(tck), .tms(tms), .tdi(tdi), .trst_n_i(trst_n_i), .trst_n_oe(trst_n_oe),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [199:0] seen, want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    while (obs_q.size() != 0) begin
      m = msk_q.pop_front();
      check(obs_q.pop_front() & m, exp_q.pop_front() & m);
    end
  end
  task automatic note(input logic [199:0] e, k, o);
    exp_q.push_back(e);
    msk_q.push_back(k);
    obs_q.push_back(o);
  endtask
  task automatic rst5();
    i_bst_jtag_ctl.xfer(200'h1f, '0, 6, to, zo);
  endtask
  task automatic ir(input logic [3:0] c);
    i_bst_jtag_ctl.xfer(200'h183, 200'({c, 4'h0}), 10, to, zo);
    note(200'({bst_pkg::IR_CAPTURE, 4'h0}), 200'hf0, to);
    note(200'hf0, 200'h3ff, zo);
  endtask
  // Scans n bits of the selected data path from idle back to idle.
  task automatic dr(input int n, input logic [199:0] d, e, k);
    logic [199:0] w;
    w = ((200'd1 << n) - 200'd1) << 3;
    i_bst_jtag_ctl.xfer((200'd3 << (n + 2)) | 200'd1, d << 3, n + 5, to, zo);
    note(w, (200'd1 << (n + 5)) - 200'd1, zo);
    note(e << 3, k << 3, to);
  endtask
  task automatic pins(input logic [15:0] e, k);
    repeat (4) @(negedge ref_clk);
    note(200'(e), 200'(k), 200'({pin_oe, pin_out}));
  endtask
  initial begin
    arst_n = 1'b0;
    core_in = '0;
    core_out = '0;
    core_oe = '0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    core_in = 8'($random(seed));
    core_out = 8'($random(seed));
    core_oe = 8'($random(seed));
    rst5();
    dr(32, '0, idv, 200'hffff_ffff);
    p = 200'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
    ext = {p[23:16], p[15:8]};
    ir(bst_pkg::INS_SAMPLE);
    dr(bst_pkg::BSC_W, p, 200'({core_oe, core_out, core_in}), 200'hff_ffff);
    pins(nrm, 16'hffff);
    ir(bst_pkg::INS_EXTEST);
    pins(ext, 16'hffff);
    foreach (bp[k]) begin
      q = 200'(unsigned'($random(seed)));
      ir(bp[k]);
      dr(8, q, q << 1, 200'hfe);
      case (bp[k])
        bst_pkg::INS_CLAMP: pins(ext, 16'hffff);
        bst_pkg::INS_HIGHZ: pins(16'h0000, 16'hff00);
        default: pins(nrm, 16'hffff);
      endcase
    end
    ir(bst_pkg::INS_EXTEST);
    i_bst_jtag_ctl.pulse(1'b0);
    pins(ext, 16'hffff);
    i_bst_jtag_ctl.pulse(1'b1);
    pins(nrm, 16'hffff);
    rst5();
    ir(bst_pkg::INS_EXTEST);
    rst5();
    pins(nrm, 16'hffff);
    ir(bst_pkg::INS_IDCODE);
    dr(32, '0, idv, 200'hffff_ffff);
    repeat (4) @(negedge ref_clk);
    end_of_test();
  end
  initial begin
    #400_000;
    miscompares++;
    end_of_test();
  end
endmodule
